// *** design/spirp_spi_port.sv ***
/*
  serial register-access port: oversamples the master's select, clock
  and data pins, decodes 16-bit frames into internal register accesses,
  returns read data, and drives the configurable interrupt pin.
  assumes core_clk is at least 8x the serial clock; pins are async.
*/
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
module spirp_spi_port
  import spirp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        cs_n_pin,
  input  wire logic        sclk_pin,
  input  wire logic        sdi_pin,
  input  wire logic        cpha_pin,
  input  wire logic        cpol_pin,
  output logic             sdo_out,
  output logic             sdo_oe,
  output logic             irq_pin_out,
  output logic             irq_pin_oe,
  output logic             irq,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic      [6:0]  acc_addr,
  output logic      [7:0]  acc_wdata,
  output logic             acc_wr,
  output logic             acc_rd,
  input  wire logic [7:0]  acc_rdata
);

  // local address match, used by both read and write decode
  function automatic logic spirp_hit(input logic [7:0] a,
                                     input logic [7:0] off);
    spirp_hit = (a == off);
  endfunction

  logic [SPIRP_NSYNC-1:0] sync1_reg;      // first stage, feeds only stage 2
  logic [SPIRP_NSYNC-1:0] sync2_reg;      // safe copies of the pins
  logic                   sclk_d_reg;     // previous safe serial clock
  logic                   mode_cpol_reg;  // strap frozen during a frame
  logic                   mode_cpha_reg;
  spirp_state_t           state_reg;
  logic [4:0]             cnt_reg;        // sampled bits in this frame
  logic [7:0]             rx_reg;         // incoming shift register
  logic [7:0]             cmd_reg;        // captured command byte
  logic [7:0]             tx_reg;         // outgoing shift register
  logic                   rd_wait_reg;    // read data due this cycle
  logic [7:0]             cfg_reg;
  logic [7:0]             stat_reg;
  logic [7:0]             mask_reg;
  logic                   sdo_reg;
  logic                   sdo_oe_reg;
  logic                   irq_pin_out_reg;
  logic                   irq_pin_oe_reg;
  logic                   irq_reg;
  logic [7:0]             rdata_reg;
  logic [6:0]             acc_addr_reg;
  logic [7:0]             acc_wdata_reg;
  logic                   acc_wr_reg;
  logic                   acc_rd_reg;

  // two-flop synchronisers, one per pin
  genvar gi;
  generate
    for (gi = 0; gi < SPIRP_NSYNC; gi++)
    begin : g_sync
      wire pin_w = (gi == SPIRP_I_CSN)  ? cs_n_pin :
                   (gi == SPIRP_I_SCLK) ? sclk_pin :
                   (gi == SPIRP_I_SDI)  ? sdi_pin  :
                   (gi == SPIRP_I_CPHA) ? cpha_pin : cpol_pin;
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          sync1_reg[gi] <= SPIRP_SYNC_RST[gi];
          sync2_reg[gi] <= SPIRP_SYNC_RST[gi];
        end
        else
        begin
          sync1_reg[gi] <= pin_w;
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // safe pin views
  wire cs_act   = ~sync2_reg[SPIRP_I_CSN];
  wire sclk_s   = sync2_reg[SPIRP_I_SCLK];
  wire sdi_s    = sync2_reg[SPIRP_I_SDI];
  wire in_frame = cs_act && (state_reg != SPIRP_IDLE);

  // [R06] idle level tells leading from trailing
  wire sclk_edge  = sclk_s ^ sclk_d_reg;
  wire lead_edge  = sclk_edge && (sclk_d_reg == mode_cpol_reg);
  wire trail_edge = sclk_edge && (sclk_d_reg != mode_cpol_reg);
  // [R05] phase strap picks sampling edge
  wire samp_edge  = in_frame && (mode_cpha_reg ? trail_edge : lead_edge);
  wire shift_edge = in_frame && (mode_cpha_reg ? lead_edge : trail_edge);

  // [R03] every incoming bit comes from the data input
  wire [7:0] rx_next  = {rx_reg[6:0], sdi_s};
  wire [4:0] cnt_next = cnt_reg + 5'h01;
  wire       cmd_end  = samp_edge && (state_reg == SPIRP_CMD)
                        && (cnt_next == SPIRP_CMD_BITS);
  wire       data_end = samp_edge && (state_reg == SPIRP_DATA)
                        && (cnt_next == SPIRP_FRAME_BITS);
  wire       is_read  = cmd_reg[SPIRP_CMD_RD_BIT];
  wire       frm_abort = (state_reg != SPIRP_IDLE) && !cs_act
                         && (state_reg != SPIRP_DONE)
                         && (cnt_reg != 5'h00);

  // register port decode
  wire wr_cfg  = reg_wr && spirp_hit(reg_addr, SPIRP_CFG_OFF);
  wire wr_mask = reg_wr && spirp_hit(reg_addr, SPIRP_MASK_OFF);
  wire rd_stat = reg_rd && spirp_hit(reg_addr, SPIRP_STAT_OFF);
  wire [7:0] rd_mux =
    spirp_hit(reg_addr, SPIRP_CFG_OFF)  ? cfg_reg  :
    spirp_hit(reg_addr, SPIRP_STAT_OFF) ? stat_reg :
    spirp_hit(reg_addr, SPIRP_MASK_OFF) ? mask_reg :
    spirp_hit(reg_addr, SPIRP_PINS_OFF) ?
      {4'h0, cs_act, mode_cpha_reg, mode_cpol_reg, in_frame} : 8'h00;

  // events set, a status read clears; a set in the same cycle wins
  wire [7:0] stat_set = {5'h00, data_end && !is_read, frm_abort, data_end};
  wire [7:0] stat_next = (rd_stat ? 8'h00 : stat_reg) | stat_set;
  wire       irq_lvl   = |(stat_next & mask_reg);

  // [R09] general output overrides the interrupt source
  wire pin_assert = cfg_reg[SPIRP_CFG_GPO_BIT] ? cfg_reg[SPIRP_CFG_VAL_BIT]
                                               : irq_lvl;
  // [R07] polarity chooses the asserted level
  wire pin_level  = cfg_reg[SPIRP_CFG_POL_BIT] ? pin_assert : ~pin_assert;
  // [R08] open drain only drives while asserted
  wire pin_oe     = cfg_reg[SPIRP_CFG_OD_BIT] ? pin_assert : 1'b1;

  // strap capture and serial clock history; straps freeze in a frame
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_d_reg    <= 1'b0;
      mode_cpol_reg <= 1'b0;
      mode_cpha_reg <= 1'b0;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      if (state_reg == SPIRP_IDLE)
      begin
        mode_cpol_reg <= sync2_reg[SPIRP_I_CPOL];
        mode_cpha_reg <= sync2_reg[SPIRP_I_CPHA];
      end
    end
  end

  // frame sequencer
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= SPIRP_IDLE;
      cnt_reg   <= 5'h00;
      rx_reg    <= 8'h00;
      cmd_reg   <= 8'h00;
    end
    // [R01] losing select ends any access at once
    else if (!cs_act)
    begin
      state_reg <= SPIRP_IDLE;
      cnt_reg   <= 5'h00;
    end
    else
    begin
      case (state_reg)
        SPIRP_IDLE: state_reg <= SPIRP_CMD;
        SPIRP_CMD:
        begin
          if (samp_edge)
          begin
            rx_reg  <= rx_next;
            cnt_reg <= cnt_next;
          end
          if (cmd_end)
          begin
            cmd_reg   <= rx_next;
            state_reg <= SPIRP_DATA;
          end
        end
        SPIRP_DATA:
        begin
          if (samp_edge)
          begin
            rx_reg  <= rx_next;
            cnt_reg <= cnt_next;
          end
          if (data_end)
            state_reg <= SPIRP_DONE;
        end
        // extra clocks after a full frame are ignored
        SPIRP_DONE: state_reg <= SPIRP_DONE;
        default:    state_reg <= SPIRP_IDLE;
      endcase
    end
  end

  // internal register accesses, one-cycle strobes
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_addr_reg  <= 7'h00;
      acc_wdata_reg <= 8'h00;
      acc_wr_reg    <= 1'b0;
      acc_rd_reg    <= 1'b0;
      rd_wait_reg   <= 1'b0;
    end
    else
    begin
      acc_rd_reg  <= cmd_end && rx_next[SPIRP_CMD_RD_BIT];
      acc_wr_reg  <= data_end && !is_read;
      rd_wait_reg <= acc_rd_reg;
      if (cmd_end)
        acc_addr_reg <= rx_next[6:0];
      if (data_end)
        acc_wdata_reg <= rx_next;
    end
  end

  // serial data out; read data loads long before the next shift edge
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_reg     <= 8'h00;
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end
    else
    begin
      // [R10] drive only while selected
      sdo_oe_reg <= cs_act;
      if (!in_frame)
      begin
        tx_reg  <= 8'h00;
        sdo_reg <= 1'b0;
      end
      // [R04] read data leaves on the data output
      else if (rd_wait_reg)
        tx_reg <= acc_rdata;
      else if (shift_edge && (state_reg != SPIRP_DONE))
      begin
        sdo_reg <= tx_reg[7];
        tx_reg  <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // local registers, interrupt and pin drive
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_reg         <= SPIRP_CFG_RST;
      mask_reg        <= SPIRP_MASK_RST;
      stat_reg        <= SPIRP_STAT_RST;
      rdata_reg       <= 8'h00;
      irq_reg         <= 1'b0;
      irq_pin_out_reg <= 1'b0;
      irq_pin_oe_reg  <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_reg <= reg_wdata;
      if (wr_mask)
        mask_reg <= reg_wdata;
      stat_reg        <= stat_next;
      rdata_reg       <= reg_rd ? rd_mux : 8'h00;
      irq_reg         <= irq_lvl;
      irq_pin_out_reg <= pin_level;
      irq_pin_oe_reg  <= pin_oe;
    end
  end

  assign sdo_out     = sdo_reg;
  assign sdo_oe      = sdo_oe_reg;
  assign irq_pin_out = irq_pin_out_reg;
  assign irq_pin_oe  = irq_pin_oe_reg;
  assign irq         = irq_reg;
  assign reg_rdata   = rdata_reg;
  assign acc_addr    = acc_addr_reg;
  assign acc_wdata   = acc_wdata_reg;
  assign acc_wr      = acc_wr_reg;
  assign acc_rd      = acc_rd_reg;

endmodule

// *** pkg/spirp_pkg.sv ***
/*
  constants of the serial register-access port: local register map,
  field positions, reset values, frame layout and fsm encoding.
  assumes a single core clock; every pin is asynchronous to it.
*/
// Summary of operation
// [R01] master holds select low for whole access
// [R02] serial clock always comes from the master
// [R03] master sends all bits on data input
// [R04] device returns read data on data output
// [R05] phase strap picks leading or trailing edge
// [R06] polarity strap sets serial clock idle level
// [R07] interrupt pin active level is configurable
// [R08] interrupt pin push-pull or open drain
// [R09] interrupt pin usable as software output
// [R10] data output floats while select is high
package spirp_pkg;

  // local register offsets on the plain register port
  localparam logic [7:0] SPIRP_CFG_OFF   = 8'h00;
  localparam logic [7:0] SPIRP_STAT_OFF  = 8'h01;
  localparam logic [7:0] SPIRP_MASK_OFF  = 8'h02;
  localparam logic [7:0] SPIRP_PINS_OFF  = 8'h03;

  // interrupt_pin_config_register fields
  localparam int         SPIRP_CFG_POL_BIT = 0;  // 1 = asserted high
  localparam int         SPIRP_CFG_OD_BIT  = 1;  // 1 = open drain
  localparam int         SPIRP_CFG_GPO_BIT = 2;  // 1 = general output
  localparam int         SPIRP_CFG_VAL_BIT = 3;  // general output value
  localparam logic [7:0] SPIRP_CFG_RST     = 8'h01;

  // status / mask fields
  localparam int         SPIRP_ST_FRAME_BIT = 0; // frame completed
  localparam int         SPIRP_ST_ABORT_BIT = 1; // select lost mid frame
  localparam int         SPIRP_ST_WR_BIT    = 2; // write issued
  localparam logic [7:0] SPIRP_STAT_RST     = 8'h00;
  localparam logic [7:0] SPIRP_MASK_RST     = 8'h00;

  // frame layout: command byte (read flag, 7-bit address), data byte
  localparam int         SPIRP_CMD_RD_BIT  = 7;
  localparam logic [4:0] SPIRP_CMD_BITS    = 5'h08;
  localparam logic [4:0] SPIRP_FRAME_BITS  = 5'h10;

  // synchroniser order {cs_n, sclk, sdi, cpha, cpol} and reset image
  localparam int         SPIRP_NSYNC      = 5;
  localparam logic [4:0] SPIRP_SYNC_RST   = 5'h10;
  localparam int         SPIRP_I_CSN      = 4;
  localparam int         SPIRP_I_SCLK     = 3;
  localparam int         SPIRP_I_SDI      = 2;
  localparam int         SPIRP_I_CPHA     = 1;
  localparam int         SPIRP_I_CPOL     = 0;

  // frame states, gray along idle -> cmd -> data -> done
  typedef enum logic [1:0]
  {
    SPIRP_IDLE = 2'b00,
    SPIRP_CMD  = 2'b01,
    SPIRP_DATA = 2'b11,
    SPIRP_DONE = 2'b10
  } spirp_state_t;

endpackage

// *** sim/spirp_master_model.sv ***
/* behavioural serial bus master for the register port.
   assumes straps stay put while a frame runs; times in ns. */
`timescale 1ns/1ns
module spirp_master_model
(
  output logic      cs_n_pin,
  output logic      sclk_pin,
  output logic      sdi_pin,
  input  wire logic cpol_pin,
  input  wire logic cpha_pin,
  input  wire logic sdo_out,
  input  wire logic sdo_oe
);
  localparam int HALF = 80;  // half of the 160 ns serial clock
  // select idles high, as its pull-up would hold it
  initial
  begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    sdi_pin  = 1'b0;
  end
  // one 16-bit frame, msb first; rx keeps the last eight bits seen
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    sclk_pin = cpol_pin;
    #50 cs_n_pin = 1'b0;
    #HALF;
    for (int i = 15; i >= 0; i--)
    begin
      if (!cpha_pin)
        sdi_pin = tx[i];
      #HALF sclk_pin = ~cpol_pin;
      if (cpha_pin)
        sdi_pin = tx[i];
      else
        rx = {rx[6:0], sdo_out & sdo_oe};
      #HALF sclk_pin = cpol_pin;
      if (cpha_pin)
        rx = {rx[6:0], sdo_out & sdo_oe};
    end
    #HALF cs_n_pin = 1'b1;
    // released line must not keep the last bit
    sdi_pin = ~sdi_pin;
    #100;
  endtask
  // a frame dropped after n clock pulses; no access may follow it
  task automatic cut(input int n);
    sclk_pin = cpol_pin;
    #50 cs_n_pin = 1'b0;
    repeat (n)
    begin
      #HALF sclk_pin = ~cpol_pin;
      #HALF sclk_pin = cpol_pin;
    end
    #HALF cs_n_pin = 1'b1;
    #100;
  endtask
endmodule

// *** sim/spirp_spi_port_asserts.sv ***
/* checker of the serial register port: data pin enable, interrupt pin
   and register read timing. assumes a bind onto spirp_spi_port. */
`timescale 1ns/1ns
module spirp_spi_port_asserts
  import spirp_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       cs_n_pin,
  input wire logic       sclk_pin,
  input wire logic       sdo_out,
  input wire logic       sdo_oe,
  input wire logic       irq_pin_out,
  input wire logic       irq_pin_oe,
  input wire logic       irq,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       acc_wr,
  input wire logic       acc_rd
);
  logic [7:0] cfg_q;  // mirror of the pin config register
  logic [7:0] cfg_p;  // the mirror as the pin flops see it
  logic       up_q;   // low on the first edge after reset
  logic       lvl;    // expected pin level; general value is polarity-mapped
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // pin flops lag the register by one cycle, hence the second stage
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_q <= SPIRP_CFG_RST;
      cfg_p <= SPIRP_CFG_RST;
      up_q  <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == SPIRP_CFG_OFF)
        cfg_q <= reg_wdata;
      cfg_p <= cfg_q;
      up_q  <= 1'b1;
    end
  end
  // general output value stands for the asserted state, like the interrupt,
  // so open drain can only ever pull towards the asserted level
  assign lvl = (cfg_p[SPIRP_CFG_GPO_BIT] ? cfg_p[SPIRP_CFG_VAL_BIT] : irq)
             ~^ cfg_p[SPIRP_CFG_POL_BIT];
  chk_oe_release: assert property (cs_n_pin [*6] |-> !sdo_oe)
    else $error("data out driven while deselected");
  chk_oe_drive: assert property (!cs_n_pin [*5] |-> sdo_oe)
    else $error("data out not driven while selected");
  chk_sdo_edges: assert property
    ((!cs_n_pin && $stable(sclk_pin)) [*8] |=> $stable(sdo_out))
    else $error("data out moved without a clock edge");
  chk_mask_off: assert property (reg_wr && reg_addr == SPIRP_MASK_OFF
    && reg_wdata == 8'h00 ##1 !(reg_wr && reg_addr == SPIRP_MASK_OFF)
    |=> !irq)
    else $error("interrupt high with all sources masked");
  chk_pin_level: assert property
    (up_q && irq_pin_oe |-> irq_pin_out == lvl)
    else $error("interrupt pin level wrong");
  chk_push_pull: assert property
    (up_q && !cfg_p[SPIRP_CFG_OD_BIT] |-> irq_pin_oe)
    else $error("push-pull pin not driven");
  chk_open_drain: assert property (up_q && cfg_p[SPIRP_CFG_OD_BIT]
    && !cfg_p[SPIRP_CFG_GPO_BIT] |-> irq_pin_oe == irq)
    else $error("open-drain pin enable wrong");
  chk_cfg_read: assert property
    (reg_rd && reg_addr == SPIRP_CFG_OFF |=> reg_rdata == cfg_q)
    else $error("config read data wrong");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_acc_framed: assert property
    (acc_wr || acc_rd |-> !cs_n_pin && !$past(cs_n_pin, 4))
    else $error("access outside a selected frame");
endmodule
bind spirp_spi_port spirp_spi_port_asserts i_chk
(
  .core_clk    (core_clk),
  .nrst        (nrst),
  .cs_n_pin    (cs_n_pin),
  .sclk_pin    (sclk_pin),
  .sdo_out     (sdo_out),
  .sdo_oe      (sdo_oe),
  .irq_pin_out (irq_pin_out),
  .irq_pin_oe  (irq_pin_oe),
  .irq         (irq),
  .reg_addr    (reg_addr),
  .reg_wdata   (reg_wdata),
  .reg_wr      (reg_wr),
  .reg_rd      (reg_rd),
  .reg_rdata   (reg_rdata),
  .acc_wr      (acc_wr),
  .acc_rd      (acc_rd)
);

// *** sim/testbench.sv ***
/* testbench of the serial register port: register port tasks, frames
   in all strap modes, interrupt pin setups. assumes the package, design,
   master model and checker are compiled before it. */
`timescale 1ns/1ns
module testbench
  import spirp_pkg::*;
;
  logic       core_clk, nrst, cs_n_pin, sclk_pin, sdi_pin;
  logic       cpha_pin, cpol_pin, sdo_out, sdo_oe, irq, reg_wr, reg_rd;
  logic       irq_pin_out, irq_pin_oe, acc_wr, acc_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, acc_wdata, acc_rdata;
  logic [7:0] wd, rx;         // last written data, frame read data
  logic [6:0] acc_addr, wa;   // access address, last written address
  int         miscompares, checks;
  logic [7:0] cfgs [8] = '{8'h01, 8'h00, 8'h03, 8'h02, 8'h0C, 8'h04,
                           8'h02, 8'h00};
  logic [1:0] pins [8] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h2, 2'h3, 2'h0,
                           2'h3};
  // pin as the board sees it: {driven, driven high}
  wire [7:0]  pin_seen = {6'h00, irq_pin_oe, irq_pin_oe & irq_pin_out};
  spirp_spi_port     i_spirp_spi_port (.*);
  spirp_master_model i_spirp_master_model (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // register file stand-in: read data follows the address
  always @(posedge core_clk)
  begin
    acc_rdata <= {1'b1, acc_addr};
    if (acc_wr)
    begin
      wa <= acc_addr;
      wd <= acc_wdata;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    {nrst, reg_wr, reg_rd, cpha_pin, cpol_pin} = 5'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    rd(SPIRP_CFG_OFF, SPIRP_CFG_RST);
    rd(SPIRP_MASK_OFF, 8'h00);
    rd(8'h04, 8'h00);
    // every strap mode: a write frame, then a read frame
    for (int m = 0; m < 4; m++)
    begin
      @(posedge core_clk);
      {cpol_pin, cpha_pin} <= m[1:0];
      @(posedge core_clk);
      i_spirp_master_model.xfer({1'b0, 7'h2A ^ m[6:0], 8'hC3 ^ m[7:0]}, rx);
      chk({1'b0, wa}, {1'b0, 7'h2A ^ m[6:0]});
      chk(wd, 8'hC3 ^ m[7:0]);
      i_spirp_master_model.xfer({1'b1, 7'h2A ^ m[6:0], 8'h00}, rx);
      chk(rx, {1'b1, 7'h2A ^ m[6:0]});
    end
    rd(SPIRP_PINS_OFF, 8'h06);
    rd(SPIRP_STAT_OFF, 8'h05);
    rd(SPIRP_STAT_OFF, 8'h00);
    // a cut frame only flags an abort, it never reaches a register
    i_spirp_master_model.cut(3);
    rd(SPIRP_STAT_OFF, 8'h02);
    chk({1'b0, wa}, 8'h29);
    chk(wd, 8'hC0);
    // only the write event is let through to the interrupt
    wr(SPIRP_MASK_OFF, 8'h04);
    i_spirp_master_model.xfer(16'h8500, rx);
    chk({7'h00, irq}, 8'h00);
    i_spirp_master_model.xfer(16'h055A, rx);
    chk({7'h00, irq}, 8'h01);
    // pin setups, first with the interrupt raised, then cleared
    for (int i = 0; i < 8; i++)
    begin
      if (i == 6)
        rd(SPIRP_STAT_OFF, 8'h05);
      wr(SPIRP_CFG_OFF, cfgs[i]);
      repeat (2) @(posedge core_clk);
      #1 chk(pin_seen, {6'h00, pins[i]});
    end
    wr(SPIRP_MASK_OFF, 8'h00);
    i_spirp_master_model.xfer(16'h0611, rx);
    chk({7'h00, irq}, 8'h00);
    give_verdict();
  end
  // a hang is cut short well after the last frame should have ended
  initial
  begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule
